// [src/airflow_i2c_readout.sv]
// Two-wire serial target that returns serial number then flow words, or status words on sensor error
`timescale 1ns/10ps
`default_nettype none

module airflow_i2c_readout
	import airflow_pkg::*;
#(
	parameter logic [6:0] TARGET_ADDR = 7'h2A,
	parameter int RESP_CYC = RESP_CYCLES
)
(
	input wire logic SYS_CLK_IN,
	input wire logic RSTN_IN,
	input wire logic SCL_IN,
	input wire logic SDA_IN,
	input wire logic [31:0] SERIAL_NUM_IN,
	input wire logic signed [15:0] FLOW_RATIO_IN,
	input wire logic SENSOR_ERR_IN,
	input wire logic [13:0] ERR_CODE_IN,
	output logic SDA_OUT,
	output logic SDA_OE_OUT,
	output logic SERIAL_DONE_OUT,
	output logic BUSY_OUT
);

	// ***************************************************************
	// Parameter checks
	// ***************************************************************
	generate
		if (RESP_CYC < 1 || RESP_CYC > 65535)
		begin : g_bad_resp
			$error("RESP_CYC out of range");
		end
	endgenerate

	// ***************************************************************
	// Reset release
	// ***************************************************************
	logic [1:0] rst_sync_ff;
	logic rst_n;

	// Two-stage release of the asynchronous reset
	always_ff @(posedge SYS_CLK_IN or negedge RSTN_IN)
	begin
		if (!RSTN_IN)
			rst_sync_ff <= 2'h0;
		else
			rst_sync_ff <= {rst_sync_ff[0], 1'b1};
	end
	assign rst_n = rst_sync_ff[1];

	// ***************************************************************
	// Flow code arithmetic
	// ***************************************************************
	logic signed [31:0] flow_prod;
	logic [15:0] flow_code;
	logic [15:0] fresh_word;

	// Scale ratio by 0.4 of full code span, offset to mid-scale
	always_comb
	begin
		flow_prod = FLOW_RATIO_IN * $signed({2'h0, FLOW_GAIN});
		flow_code = FLOW_MID + 16'(flow_prod >>> RATIO_FRAC);
		if (SENSOR_ERR_IN)
			fresh_word = {TAG_STATUS, ERR_CODE_IN};
		else
			fresh_word = {TAG_FLOW, flow_code[CODE_W-1:0]};
	end

	// ***************************************************************
	// Target state machine
	// ***************************************************************
	tgt_reg_s st_ff;
	tgt_reg_s nxt_st;
	logic scl_rise;
	logic scl_fall;
	logic start_cond;
	logic stop_cond;
	logic [15:0] load_word;

	assign scl_rise = SCL_IN && !st_ff.scl_q;
	assign scl_fall = !SCL_IN && st_ff.scl_q;
	assign start_cond = SCL_IN && st_ff.scl_q && st_ff.sda_q && !SDA_IN;
	assign stop_cond = SCL_IN && st_ff.scl_q && !st_ff.sda_q && SDA_IN;

	// Word for the read now starting
	always_comb
	begin
		case (st_ff.rd_cnt)
			2'h0: load_word = SERIAL_NUM_IN[31:16];
			2'h1: load_word = SERIAL_NUM_IN[15:0];
			default: load_word = st_ff.flow_hold;
		endcase
	end

	// Next state of all target registers
	always_comb
	begin
		nxt_st = st_ff;
		nxt_st.scl_q = SCL_IN;
		nxt_st.sda_q = SDA_IN;
		nxt_st.tick = 1'b0;
		// Result refresh timer
		if (st_ff.tick_cnt == 16'(RESP_CYC - 1))
		begin
			nxt_st.tick_cnt = 16'h0000;
			nxt_st.tick = 1'b1;
		end
		else
			nxt_st.tick_cnt = st_ff.tick_cnt + 16'h0001;
		if (st_ff.tick)
			nxt_st.flow_hold = fresh_word;
		// Bus sequencing
		if (start_cond)
		begin
			nxt_st.state = ST_ADDR;
			nxt_st.bit_cnt = 3'h0;
			nxt_st.sda_oe = 1'b0;
		end
		else if (stop_cond)
		begin
			nxt_st.state = ST_IDLE;
			nxt_st.sda_oe = 1'b0;
		end
		else
		begin
			case (st_ff.state)
				ST_IDLE:
					nxt_st.sda_oe = 1'b0;
				ST_ADDR:
				begin
					if (scl_rise)
					begin
						nxt_st.shift = {st_ff.shift[6:0], SDA_IN};
						nxt_st.bit_cnt = st_ff.bit_cnt + 3'h1;
						if (st_ff.bit_cnt == 3'h7)
							nxt_st.ack_ok = 1'b1;
					end
					else if (scl_fall && st_ff.ack_ok)
					begin
						nxt_st.ack_ok = 1'b0;
						// Only reads to our own address
						if (st_ff.shift == {TARGET_ADDR, 1'b1})
						begin
							nxt_st.state = ST_AACK;
							nxt_st.sda_oe = 1'b1;
						end
						else
							nxt_st.state = ST_IDLE;
					end
				end
				ST_AACK:
				begin
					if (scl_fall)
					begin
						nxt_st.word = load_word;
						nxt_st.hi_byte = 1'b1;
						nxt_st.bit_cnt = 3'h0;
						nxt_st.sda_oe = !load_word[15];
						nxt_st.state = ST_TX;
						if (st_ff.rd_cnt != READS_SERIAL)
							nxt_st.rd_cnt = st_ff.rd_cnt + 2'h1;
					end
				end
				ST_TX:
				begin
					if (scl_fall)
					begin
						if (st_ff.bit_cnt == 3'h7)
						begin
							nxt_st.sda_oe = 1'b0;
							nxt_st.state = ST_TACK;
						end
						else
						begin
							nxt_st.bit_cnt = st_ff.bit_cnt + 3'h1;
							nxt_st.word = {st_ff.word[14:0], 1'b0};
							nxt_st.sda_oe = !st_ff.word[14];
						end
					end
				end
				ST_TACK:
				begin
					if (scl_rise)
						nxt_st.ack_ok = !SDA_IN && st_ff.hi_byte;
					else if (scl_fall)
					begin
						nxt_st.ack_ok = 1'b0;
						if (st_ff.ack_ok)
						begin
							// Second byte of the word
							nxt_st.word = {st_ff.word[14:0], 1'b0};
							nxt_st.hi_byte = 1'b0;
							nxt_st.bit_cnt = 3'h0;
							nxt_st.sda_oe = !st_ff.word[14];
							nxt_st.state = ST_TX;
						end
						else
							nxt_st.state = ST_IDLE;
					end
				end
				default:
					nxt_st.state = ST_IDLE;
			endcase
		end
		nxt_st.serial_done = (nxt_st.rd_cnt == READS_SERIAL);
		nxt_st.busy = (nxt_st.state != ST_IDLE);
	end

	// State register
	always_ff @(posedge SYS_CLK_IN or negedge rst_n)
	begin
		if (!rst_n)
			st_ff <= TGT_RESET;
		else
			st_ff <= nxt_st;
	end

	// Open-drain data: only ever pulls low
	assign SDA_OUT = 1'b0;
	assign SDA_OE_OUT = st_ff.sda_oe;
	assign SERIAL_DONE_OUT = st_ff.serial_done;
	assign BUSY_OUT = st_ff.busy;

	// ***************************************************************
	// Assertions
	// ***************************************************************
	logic first_load;
	assign first_load = (st_ff.state == ST_AACK) && scl_fall;

	property p_serial_hi;
		@(posedge SYS_CLK_IN) disable iff (!rst_n)
		first_load && st_ff.rd_cnt == 2'h0
			|=> st_ff.word == $past(SERIAL_NUM_IN[31:16]);
	endproperty
	a_serial_hi: assert property (p_serial_hi)
		else $error("first read not upper serial half");

	property p_serial_lo;
		@(posedge SYS_CLK_IN) disable iff (!rst_n)
		first_load && st_ff.rd_cnt == 2'h1
			|=> st_ff.word == $past(SERIAL_NUM_IN[15:0]);
	endproperty
	a_serial_lo: assert property (p_serial_lo)
		else $error("second read not lower serial half");

	property p_serial_count;
		@(posedge SYS_CLK_IN) disable iff (!rst_n)
		first_load && st_ff.rd_cnt == 2'h1 |=> ##1 SERIAL_DONE_OUT;
	endproperty
	a_serial_count: assert property (p_serial_count)
		else $error("serial phase not over after two reads");

	property p_flow_read;
		@(posedge SYS_CLK_IN) disable iff (!rst_n)
		first_load && st_ff.rd_cnt == READS_SERIAL
			|=> st_ff.word == $past(st_ff.flow_hold);
	endproperty
	a_flow_read: assert property (p_flow_read)
		else $error("later read not the flow word");

	property p_refresh;
		@(posedge SYS_CLK_IN) disable iff (!rst_n)
		!$stable(st_ff.flow_hold) |-> $past(st_ff.tick);
	endproperty
	a_refresh: assert property (p_refresh)
		else $error("flow word changed between refresh ticks");

	property p_flow_tag;
		@(posedge SYS_CLK_IN) disable iff (!rst_n)
		st_ff.tick && !SENSOR_ERR_IN |=> st_ff.flow_hold[15:14] == 2'h0;
	endproperty
	a_flow_tag: assert property (p_flow_tag)
		else $error("flow word prefix not 00");

	property p_err_tag;
		@(posedge SYS_CLK_IN) disable iff (!rst_n)
		st_ff.tick && SENSOR_ERR_IN |=> st_ff.flow_hold[15:14] == 2'h3;
	endproperty
	a_err_tag: assert property (p_err_tag)
		else $error("status word prefix not 11");

	property p_zero_flow;
		@(posedge SYS_CLK_IN) disable iff (!rst_n)
		st_ff.tick && !SENSOR_ERR_IN && FLOW_RATIO_IN == 16'sh0000
			|=> st_ff.flow_hold == 16'h2000;
	endproperty
	a_zero_flow: assert property (p_zero_flow)
		else $error("zero flow not mid-scale");

	property p_addr_match;
		@(posedge SYS_CLK_IN) disable iff (!rst_n)
		st_ff.state == ST_AACK |-> st_ff.shift == {TARGET_ADDR, 1'b1};
	endproperty
	a_addr_match: assert property (p_addr_match)
		else $error("acknowledged a foreign address or a write");

	c_addr_ack: cover property (@(posedge SYS_CLK_IN) disable iff (!rst_n)
		st_ff.state == ST_AACK);
	c_second_byte: cover property (@(posedge SYS_CLK_IN)
		disable iff (!rst_n) st_ff.state == ST_TX && !st_ff.hi_byte);
	c_flow_phase: cover property (@(posedge SYS_CLK_IN)
		disable iff (!rst_n) first_load && st_ff.rd_cnt == READS_SERIAL);

endmodule // airflow_i2c_readout

`default_nettype wire

// [pkg/airflow_pkg.sv]
// Shared constants and types for the airflow sensor serial readout
package airflow_pkg;

	// ***************************************************************
	// Timing
	// ***************************************************************
	localparam int CLK_FREQ_KHZ = 10000;    // System clock, 10 MHz
	localparam int RESP_TIME_US = 1000;     // Flow result refresh interval
	localparam int RESP_CYCLES = (RESP_TIME_US * CLK_FREQ_KHZ) / 1000;

	// ***************************************************************
	// Word layout and transfer function
	// ***************************************************************
	localparam int WORD_W = 16;
	localparam int CODE_W = 14;
	localparam logic [1:0] TAG_FLOW = 2'h0;     // Prefix of flow words
	localparam logic [1:0] TAG_STATUS = 2'h3;   // Prefix of status words
	localparam logic [15:0] FLOW_MID = 16'h2000; // 16384 * 0.5
	localparam logic [13:0] FLOW_GAIN = 14'h199A; // 16384 * 0.4, rounded
	localparam int RATIO_FRAC = 15;              // Ratio input is Q1.15
	localparam logic [1:0] READS_SERIAL = 2'h2;  // Reads carrying serial no.

	// ***************************************************************
	// Target state machine
	// ***************************************************************
	typedef enum logic [4:0] {
		ST_IDLE = 5'h01,
		ST_ADDR = 5'h02,
		ST_AACK = 5'h04,
		ST_TX = 5'h08,
		ST_TACK = 5'h10
	} tgt_state_e;

	typedef struct packed {
		tgt_state_e state;
		logic scl_q;
		logic sda_q;
		logic [2:0] bit_cnt;
		logic [7:0] shift;
		logic [15:0] word;
		logic hi_byte;
		logic ack_ok;
		logic [1:0] rd_cnt;
		logic [15:0] flow_hold;
		logic [15:0] tick_cnt;
		logic tick;
		logic sda_oe;
		logic serial_done;
		logic busy;
	} tgt_reg_s;

	localparam tgt_reg_s TGT_RESET = '{
		state: ST_IDLE, scl_q: 1'b1, sda_q: 1'b1, bit_cnt: 3'h0,
		shift: 8'h00, word: 16'h0000, hi_byte: 1'b1, ack_ok: 1'b0,
		rd_cnt: 2'h0, flow_hold: FLOW_MID, tick_cnt: 16'h0000,
		tick: 1'b0, sda_oe: 1'b0, serial_done: 1'b0, busy: 1'b0};

endpackage

// [dv/airflow_bus_ctrl.sv]
// Behavioural two-wire bus controller issuing reads
`timescale 1ns/10ps
`default_nettype none

module airflow_bus_ctrl
(
	input wire logic clk_in,
	input wire logic sda_in,
	output logic scl_out,
	output logic sda_pull_out
);
	int half_cyc = 4; // Raise to slow the bus down

	// Idle bus: clock high, data released
	initial
	begin
		scl_out = 1'b1;
		sda_pull_out = 1'b0;
	end

	// One phase of the bus clock
	task automatic half();
		repeat (half_cyc) @(posedge clk_in);
	endtask

	// Drive one bit, sample the wire late in the high phase
	task automatic bit_xfer(input logic b, output logic r);
		half();
		sda_pull_out <= ~b;
		half();
		scl_out <= 1'b1;
		half();
		r = sda_in;
		scl_out <= 1'b0;
	endtask

	// Whole byte, most significant bit first
	task automatic byte_xfer(input logic [7:0] b, output logic [7:0] r);
		for (int i = 7; i >= 0; i--)
			bit_xfer(b[i], r[i]);
	endtask

	// Start, address, two bytes (ACK then NACK), stop
	task automatic read_word(input logic [6:0] a, input logic rw,
		output logic ack, output logic [15:0] w);
		logic r;
		sda_pull_out <= 1'b1;
		half();
		scl_out <= 1'b0;
		byte_xfer({a, rw}, w[7:0]);
		bit_xfer(1'b1, r);
		ack = ~r;
		if (ack)
		begin
			byte_xfer(8'hFF, w[15:8]);
			bit_xfer(1'b0, r);
			byte_xfer(8'hFF, w[7:0]);
			bit_xfer(1'b1, r);
		end
		half();
		sda_pull_out <= 1'b1;
		half();
		scl_out <= 1'b1;
		half();
		sda_pull_out <= 1'b0;
		half();
	endtask
endmodule // airflow_bus_ctrl

`default_nettype wire

// [dv/tb_airflow_i2c_readout.sv]
// Self-checking bench for the airflow serial readout
`timescale 1ns/10ps
`default_nettype none

module tb_airflow_i2c_readout
	import airflow_pkg::*;
;
	localparam logic [6:0] TGT = 7'h2A;
	localparam int RESP = 50;
	typedef struct packed {
		logic [6:0] addr;
		logic signed [15:0] ratio;
		logic err;
		logic ack;
		logic done;
		logic [15:0] word;
	} row_s;
	row_s rows [9];
	logic clk = 1'b0;
	logic rstn = 1'b0;
	logic [31:0] serial = 32'hA5C31E0F;
	logic signed [15:0] ratio = 16'sh0000;
	logic err = 1'b0;
	logic [13:0] code = 14'h1234;
	logic scl, sda, pull, sda_oe, sda_do, done, busy, ack;
	logic [15:0] w;
	int n_fail = 0;
	int tests_run = 0;

	// Open-drain wire with pull-up
	assign sda = ~pull & (~sda_oe | sda_do);

	airflow_i2c_readout #(.TARGET_ADDR(TGT), .RESP_CYC(RESP)) i_dut (
		.SYS_CLK_IN(clk), .RSTN_IN(rstn), .SCL_IN(scl), .SDA_IN(sda),
		.SERIAL_NUM_IN(serial), .FLOW_RATIO_IN(ratio),
		.SENSOR_ERR_IN(err), .ERR_CODE_IN(code), .SDA_OUT(sda_do),
		.SDA_OE_OUT(sda_oe), .SERIAL_DONE_OUT(done), .BUSY_OUT(busy));

	airflow_bus_ctrl i_ctrl (.clk_in(clk), .sda_in(sda), .scl_out(scl),
		.sda_pull_out(pull));

	// Clock
	always #50 clk = ~clk;

	// **********************************************
	// Helpers
	// **********************************************
	task automatic check(input logic [15:0] seen, input logic [15:0] exp);
		tests_run++;
		if (seen !== exp)
		begin
			n_fail++;
			$display("MISMATCH t=%0t seen %h exp %h", $time, seen, exp);
		end
	endtask

	function automatic logic [15:0] exp_flow(input logic signed [15:0] r);
		longint p;
		p = (longint'(r) * longint'(FLOW_GAIN)) >>> RATIO_FRAC;
		return {TAG_FLOW, 14'(longint'(FLOW_MID) + p)};
	endfunction

	task automatic do_reset();
		rstn <= 1'b0;
		repeat (4) @(posedge clk);
		check({13'h0000, sda_oe, done, busy}, 16'h0000);
		rstn <= 1'b1;
		repeat (20) @(posedge clk); // startup wait
	endtask

	task automatic rd_chk(input logic [15:0] exp, input logic dn);
		repeat (RESP + 5) @(posedge clk); // gap, scaled
		i_ctrl.read_word(TGT, 1'b1, ack, w);
		check(w, exp);
		check(16'(done), 16'(dn));
	endtask

	task automatic print_verdict();
		$display("checks %0d mismatches %0d", tests_run, n_fail);
		if (n_fail == 0 && tests_run > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask

	// **********************************************
	// Main sequence
	// **********************************************
	initial
	begin
		rows[0] = '{7'h2B, 16'sh0000, 1'b0, 1'b0, 1'b0, 16'h0000};
		rows[1] = '{TGT, 16'sh0000, 1'b0, 1'b1, 1'b0, 16'hA5C3};
		rows[2] = '{TGT, 16'sh0000, 1'b0, 1'b1, 1'b1, 16'h1E0F};
		rows[3] = '{TGT, 16'sh4000, 1'b0, 1'b1, 1'b1, exp_flow(16'sh4000)};
		rows[4] = '{TGT, 16'sh7FFF, 1'b0, 1'b1, 1'b1, exp_flow(16'sh7FFF)};
		rows[5] = '{TGT, 16'sh8000, 1'b0, 1'b1, 1'b1, exp_flow(16'sh8000)};
		rows[6] = '{TGT, 16'sh0000, 1'b0, 1'b1, 1'b1, exp_flow(16'sh0000)};
		rows[7] = '{TGT, 16'sh0000, 1'b1, 1'b1, 1'b1, {TAG_STATUS, code}};
		rows[8] = '{7'h6A, 16'sh0000, 1'b0, 1'b0, 1'b1, 16'h0000};
		do_reset();
		foreach (rows[i])
		begin
			ratio <= rows[i].ratio;
			err <= rows[i].err;
			repeat (RESP + 5) @(posedge clk); // gap, scaled
			i_ctrl.read_word(rows[i].addr, 1'b1, ack, w);
			check(16'(ack), 16'(rows[i].ack));
			if (rows[i].ack)
				check(w, rows[i].word);
			check(16'(done), 16'(rows[i].done));
			check(16'(busy), 16'h0000);
			$display("row %0d finished", i);
		end
		// Write direction refused, later read still served
		i_ctrl.read_word(TGT, 1'b0, ack, w);
		check(16'(ack), 16'h0000);
		ratio <= 16'sh4000;
		rd_chk(exp_flow(16'sh4000), 1'b1);
		$display("refused write finished");
		// Second reset, slow bus: serial number again
		serial <= 32'h13579BDF;
		i_ctrl.half_cyc = 7;
		do_reset();
		rd_chk(16'h1357, 1'b0);
		rd_chk(16'h9BDF, 1'b1);
		$display("second reset finished");
		print_verdict();
	end

	// Watchdog
	initial
	begin
		repeat (30000) @(posedge clk);
		n_fail++;
		print_verdict();
	end
endmodule // tb_airflow_i2c_readout

`default_nettype wire
